// ==== logic/lsba_core.sv ====
// execution datapath for logical, shift, rotate and single-bit operations

// How it works
// - and destination with register or immediate
// - or destination with register or immediate
// - xor destination with register or immediate
// - destination becomes its one's complement
// - arithmetic shifts by one or two
// - logical shifts by one or two, zero fill
// - plain rotates by one or two
// - rotates through carry by one or two
// - sizes b/w/l; bit operations byte only
// - bit set forces selected bit one
// - bit clear forces selected bit zero
// - bit invert toggles selected bit
// - bit test: zero gets inverted bit
// - carry ands with selected bit
// - carry ands with inverted bit, immediate index
// - carry ors with selected bit
// - carry ors with inverted bit, immediate index
module lsba_core
  import lsba_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  input  wire lsba_req_s         req,
  output logic                   res_valid,
  output logic      [DATA_W-1:0] res_data,
  output logic                   res_write,
  output lsba_flags_s            flags
);
  logic [DATA_W-1:0] rhs;
  logic [DATA_W-1:0] logic_res;
  logic [DATA_W-1:0] sh1_out;
  logic [DATA_W-1:0] sh2_out;
  logic              sh1_c;
  logic              sh2_c;
  logic [DATA_W-1:0] sized;
  logic [DATA_W-1:0] size_mask;
  logic [DATA_W-1:0] res_d;
  logic              wr_d;
  logic [BIDX_W-1:0] bidx;
  logic [BYTE_W-1:0] byte_in;
  logic [BYTE_W-1:0] byte_out;
  logic              sel_bit;
  logic              is_shift;
  logic              is_logic;
  lsba_flags_s       flags_d;
  lsba_flags_s       flags_q;
  logic [DATA_W-1:0] res_q;
  logic              wr_q;
  logic              valid_q;

  assign rhs = req.use_imm ? req.imm : req.src;

  // logic results replace only the operand-sized part of the destination
  always_comb begin
    if (req.size == LSBA_SZ_BYTE) begin
      size_mask = {{(DATA_W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}};
    end else if (req.size == LSBA_SZ_WORD) begin
      size_mask = {{(DATA_W-WORD_W){1'b0}}, {WORD_W{1'b1}}};
    end else begin
      size_mask = '1;
    end
  end

  always_comb begin
    case (req.op)
      LSBA_OP_AND: logic_res = req.dst & rhs;
      LSBA_OP_OR:  logic_res = req.dst | rhs;
      LSBA_OP_XOR: logic_res = req.dst ^ rhs;
      default:     logic_res = ~req.dst;
    endcase
  end

  // two chained one-step stages; the second is bypassed for one-bit shifts
  lsba_shift1 u_step1 (
    .din  (req.dst),
    .cin  (flags_q.c),
    .op   (req.op),
    .size (req.size),
    .dout (sh1_out),
    .cout (sh1_c)
  );

  lsba_shift1 u_step2 (
    .din  (sh1_out),
    .cin  (sh1_c),
    .op   (req.op),
    .size (req.size),
    .dout (sh2_out),
    .cout (sh2_c)
  );

  // bit operations look at the low byte only
  assign byte_in = req.dst[BYTE_W-1:0];

  always_comb begin
    // inverted-bit carry operations take the immediate index only
    if (req.idx_from_reg && req.op != LSBA_OP_CARRY_AND_INVERTED_BIT
        && req.op != LSBA_OP_CARRY_OR_INVERTED_BIT) begin
      bidx = req.src[BIDX_W-1:0];
    end else begin
      bidx = req.idx_imm;
    end
  end

  assign sel_bit = byte_in[bidx];

  always_comb begin
    byte_out = byte_in;
    case (req.op)
      LSBA_OP_BIT_SET:    byte_out[bidx] = 1'b1;
      LSBA_OP_BIT_CLEAR:  byte_out[bidx] = 1'b0;
      LSBA_OP_BIT_INVERT: byte_out[bidx] = ~sel_bit;
      default: ;
    endcase
  end

  always_comb begin
    is_logic = req.op inside {LSBA_OP_AND, LSBA_OP_OR, LSBA_OP_XOR, LSBA_OP_NOT};
    is_shift = req.op inside {LSBA_OP_ARITH_SHIFT_LEFT, LSBA_OP_ARITH_SHIFT_RIGHT,
                              LSBA_OP_LOGIC_SHIFT_LEFT, LSBA_OP_LOGIC_SHIFT_RIGHT,
                              LSBA_OP_ROTATE_LEFT, LSBA_OP_ROTATE_RIGHT,
                              LSBA_OP_ROTATE_LEFT_VIA_CARRY,
                              LSBA_OP_ROTATE_RIGHT_VIA_CARRY};
  end

  always_comb begin
    flags_d = flags_q;
    res_d   = req.dst;
    wr_d    = 1'b0;
    if (is_logic) begin
      res_d = (logic_res & size_mask) | (req.dst & ~size_mask);
      wr_d  = 1'b1;
    end else if (is_shift) begin
      res_d   = req.two_bits ? sh2_out : sh1_out;
      flags_d.c = req.two_bits ? sh2_c : sh1_c;
      wr_d    = 1'b1;
    end else begin
      case (req.op)
        LSBA_OP_BIT_SET, LSBA_OP_BIT_CLEAR, LSBA_OP_BIT_INVERT: begin
          res_d = {req.dst[DATA_W-1:BYTE_W], byte_out};
          wr_d  = 1'b1;
        end
        LSBA_OP_BIT_TEST:               flags_d.z = ~sel_bit;
        LSBA_OP_CARRY_AND_BIT:          flags_d.c = flags_q.c & sel_bit;
        LSBA_OP_CARRY_AND_INVERTED_BIT: flags_d.c = flags_q.c & ~sel_bit;
        LSBA_OP_CARRY_OR_BIT:           flags_d.c = flags_q.c | sel_bit;
        LSBA_OP_CARRY_OR_INVERTED_BIT:  flags_d.c = flags_q.c | ~sel_bit;
        default: ;
      endcase
    end
    // flags judged at the operand size only; upper bits would mislead them
    sized = res_d;
    case (req.size)
      LSBA_SZ_BYTE: sized = {{(DATA_W-BYTE_W){1'b0}}, res_d[BYTE_W-1:0]};
      LSBA_SZ_WORD: sized = {{(DATA_W-WORD_W){1'b0}}, res_d[WORD_W-1:0]};
      default: ;
    endcase
    if (is_logic || is_shift) begin
      flags_d.z = (sized == '0);
      case (req.size)
        LSBA_SZ_BYTE: flags_d.n = res_d[BYTE_W-1];
        LSBA_SZ_WORD: flags_d.n = res_d[WORD_W-1];
        default:      flags_d.n = res_d[DATA_W-1];
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RST;
    end else if (clk_en && req_valid) begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      res_q   <= '0;
      wr_q    <= 1'b0;
      valid_q <= 1'b0;
    end else if (clk_en) begin
      valid_q <= req_valid;
      if (req_valid) begin
        res_q <= res_d;
        wr_q  <= wr_d;
      end else begin
        wr_q  <= 1'b0;
      end
    end
  end

  assign res_valid = valid_q;
  assign res_data  = res_q;
  assign res_write = wr_q;
  assign flags     = flags_q;
endmodule

// ==== logic/lsba_pkg.sv ====
// shared constants and types for the logic, shift and bit datapath
package lsba_pkg;
  localparam int DATA_W   = 32;
  localparam int BYTE_W   = 8;
  localparam int WORD_W   = 16;
  localparam int BIDX_W   = 3;

  typedef enum logic [1:0] {
    LSBA_SZ_BYTE,
    LSBA_SZ_WORD,
    LSBA_SZ_LONG
  } lsba_size_e;

  typedef enum logic [4:0] {
    LSBA_OP_AND,
    LSBA_OP_OR,
    LSBA_OP_XOR,
    LSBA_OP_NOT,
    LSBA_OP_ARITH_SHIFT_LEFT,
    LSBA_OP_ARITH_SHIFT_RIGHT,
    LSBA_OP_LOGIC_SHIFT_LEFT,
    LSBA_OP_LOGIC_SHIFT_RIGHT,
    LSBA_OP_ROTATE_LEFT,
    LSBA_OP_ROTATE_RIGHT,
    LSBA_OP_ROTATE_LEFT_VIA_CARRY,
    LSBA_OP_ROTATE_RIGHT_VIA_CARRY,
    LSBA_OP_BIT_SET,
    LSBA_OP_BIT_CLEAR,
    LSBA_OP_BIT_INVERT,
    LSBA_OP_BIT_TEST,
    LSBA_OP_CARRY_AND_BIT,
    LSBA_OP_CARRY_AND_INVERTED_BIT,
    LSBA_OP_CARRY_OR_BIT,
    LSBA_OP_CARRY_OR_INVERTED_BIT
  } lsba_op_e;

  // one operation request
  typedef struct packed {
    lsba_op_e             op;
    lsba_size_e           size;
    logic                 use_imm;
    logic                 two_bits;
    logic                 idx_from_reg;
    logic [BIDX_W-1:0]    idx_imm;
    logic [DATA_W-1:0]    dst;
    logic [DATA_W-1:0]    src;
    logic [DATA_W-1:0]    imm;
  } lsba_req_s;

  // flags held by the datapath
  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } lsba_flags_s;

  localparam lsba_flags_s FLAGS_RST = '{n: 1'b0, z: 1'b0, c: 1'b0};
endpackage

// ==== logic/lsba_shift1.sv ====
// one-position shift or rotate step at a chosen operand size
module lsba_shift1
  import lsba_pkg::*;
(
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              cin,
  input  wire lsba_op_e          op,
  input  wire lsba_size_e        size,
  output logic      [DATA_W-1:0] dout,
  output logic                   cout
);
  logic [DATA_W-1:0] v;
  logic              msb;
  logic              lsb;
  logic              in_l;
  logic              in_r;
  int                top;

  always_comb begin
    top = (size == LSBA_SZ_BYTE) ? BYTE_W - 1 : (size == LSBA_SZ_WORD) ? WORD_W - 1 : DATA_W - 1;
    v   = din;
    msb = din[top];
    lsb = din[0];
    in_l = 1'b0;
    in_r = 1'b0;
    case (op)
      LSBA_OP_ARITH_SHIFT_RIGHT:      in_r = msb;
      LSBA_OP_ROTATE_LEFT:            in_l = msb;
      LSBA_OP_ROTATE_RIGHT:           in_r = lsb;
      LSBA_OP_ROTATE_LEFT_VIA_CARRY:  in_l = cin;
      LSBA_OP_ROTATE_RIGHT_VIA_CARRY: in_r = cin;
      default: ;
    endcase
    case (op)
      LSBA_OP_ARITH_SHIFT_RIGHT, LSBA_OP_LOGIC_SHIFT_RIGHT,
      LSBA_OP_ROTATE_RIGHT, LSBA_OP_ROTATE_RIGHT_VIA_CARRY: begin
        v = din >> 1;
        v[top] = in_r;
        cout = lsb;
      end
      default: begin
        v = {din[DATA_W-2:0], in_l};
        cout = msb;
      end
    endcase
    // bits above the operand size stay as they were
    for (int i = 0; i < DATA_W; i++) begin
      if (i > top) begin
        v[i] = din[i];
      end
    end
    dout = v;
  end
endmodule

// ==== test/lsba_core_monitor.sv ====
// assertions on the ports of the logic, shift and bit datapath
module lsba_core_monitor
  import lsba_pkg::*;
(
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              clk_en,
  input wire logic              req_valid,
  input wire lsba_req_s         req,
  input wire logic              res_valid,
  input wire logic [DATA_W-1:0] res_data,
  input wire logic              res_write,
  input wire lsba_flags_s       flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  lsba_req_s  p_q;
  logic [2:0] ix;
  wire        t = clk_en && req_valid;
  // request seen at the taking edge, compared one edge later
  always_ff @(posedge clock) p_q <= req;
  assign ix = p_q.idx_from_reg ? p_q.src[2:0] : p_q.idx_imm;
  a_and_result: assert property (t && req.op == LSBA_OP_AND && req.size == LSBA_SZ_LONG
    |=> res_data == (p_q.dst & (p_q.use_imm ? p_q.imm : p_q.src))) else $error("and result");
  a_or_result: assert property (t && req.op == LSBA_OP_OR && req.size == LSBA_SZ_LONG
    |=> res_data == (p_q.dst | (p_q.use_imm ? p_q.imm : p_q.src))) else $error("or result");
  a_not_long: assert property (t && req.op == LSBA_OP_NOT && req.size == LSBA_SZ_LONG
    |=> res_data == ~p_q.dst) else $error("not result");
  a_bit_set: assert property (t && req.op == LSBA_OP_BIT_SET
    |=> res_data[7:0] == (p_q.dst[7:0] | (8'h01 << ix)) && res_write) else $error("bit set");
  a_bit_clear: assert property (t && req.op == LSBA_OP_BIT_CLEAR
    |=> res_data[7:0] == (p_q.dst[7:0] & ~(8'h01 << ix))) else $error("bit clear");
  a_bit_test: assert property (t && req.op == LSBA_OP_BIT_TEST
    |=> flags.z == !p_q.dst[ix] && !res_write) else $error("bit test");
  a_carry_and: assert property (t && req.op == LSBA_OP_CARRY_AND_BIT
    |=> flags.c == ($past(flags.c) & p_q.dst[ix])) else $error("carry and");
  a_carry_ior: assert property (t && req.op == LSBA_OP_CARRY_OR_INVERTED_BIT
    |=> flags.c == ($past(flags.c) | !p_q.dst[p_q.idx_imm])) else $error("carry or inv");
  a_shr_carry: assert property (t && req.op == LSBA_OP_LOGIC_SHIFT_RIGHT && !req.two_bits
    |=> flags.c == p_q.dst[0] && res_valid) else $error("shift carry");
  a_size_keep: assert property (t && req.size == LSBA_SZ_BYTE
    && req.op inside {LSBA_OP_AND, LSBA_OP_OR, LSBA_OP_XOR, LSBA_OP_NOT}
    |=> res_data[31:8] == p_q.dst[31:8]) else $error("upper bits changed");
  a_enable_freeze: assert property (!clk_en
    |=> $stable(res_data) && $stable(flags) && $stable(res_valid)) else $error("state moved");
endmodule

bind lsba_core lsba_core_monitor u_mon (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
  .req_valid(req_valid), .req(req), .res_valid(res_valid), .res_data(res_data),
  .res_write(res_write), .flags(flags));

// ==== test/tb_lsba_core.sv ====
// testbench for the logic, shift and bit datapath
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_lsba_core
  import lsba_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, reset_n, clk_en, req_valid, res_valid, res_write;
  lsba_req_s   req;
  logic [31:0] res_data;
  lsba_flags_s flags;
  int          error_cnt, checked, cyc;
  lsba_core DUT (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .res_valid(res_valid), .res_data(res_data), .res_write(res_write), .flags(flags));
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // far above the roughly 72 cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks made %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // immediate index is x[5:3] so it differs from the register index x[2:0]
  task automatic go(lsba_op_e o, lsba_size_e s, logic [31:0] d, x, logic tb = 0, ui = 0, fr = 0);
    @(posedge clock) #1;
    req = '{op: o, size: s, use_imm: ui, two_bits: tb, idx_from_reg: fr, idx_imm: x[5:3],
            dst: d, src: x, imm: ~x};
    req_valid = 1;
    @(posedge clock) #1;
    req_valid = 0;
    `CHK(res_valid, 1'b1)
  endtask
  task automatic t_logic();
    logic [31:0] d = 32'hF0F0_1234, x = 32'h8FF0_FF00;
    go(LSBA_OP_AND, LSBA_SZ_LONG, d, x);
    `CHK(res_data, d & x)
    `CHK(flags.n, 1'b1)
    go(LSBA_OP_OR, LSBA_SZ_LONG, d, x, 0, 1);
    `CHK(res_data, d | ~x)
    go(LSBA_OP_XOR, LSBA_SZ_WORD, d, x);
    `CHK(res_data, {d[31:16], d[15:0] ^ x[15:0]})
    go(LSBA_OP_AND, LSBA_SZ_BYTE, d, x);
    `CHK(flags.z, 1'b1)
    go(LSBA_OP_NOT, LSBA_SZ_BYTE, d, x);
    `CHK(res_data, {d[31:8], ~d[7:0]})
    `CHK(res_write, 1'b1)
    go(LSBA_OP_NOT, LSBA_SZ_LONG, d, x);
    `CHK(res_data, ~d)
  endtask
  task automatic t_shift();
    go(LSBA_OP_LOGIC_SHIFT_RIGHT, LSBA_SZ_BYTE, 32'h83, 0, 1);
    `CHK({res_data[7:0], flags.c}, 9'h041)
    go(LSBA_OP_ARITH_SHIFT_RIGHT, LSBA_SZ_BYTE, 32'h81, 0);
    `CHK({res_data[7:0], flags.n}, 9'h181)
    go(LSBA_OP_ARITH_SHIFT_LEFT, LSBA_SZ_LONG, 32'h6000_0001, 0, 1);
    `CHK({res_data, flags.c}, 33'h1_0000_0009)
    go(LSBA_OP_ROTATE_LEFT, LSBA_SZ_WORD, 32'h1234_8001, 0);
    `CHK({res_data, flags.c}, 33'h0_2468_0007)
    go(LSBA_OP_ROTATE_RIGHT_VIA_CARRY, LSBA_SZ_BYTE, 32'h02, 0);
    `CHK({res_data[7:0], flags.c}, 9'h102)
    go(LSBA_OP_ROTATE_LEFT_VIA_CARRY, LSBA_SZ_BYTE, 32'h80, 0, 1);
    `CHK({res_data[7:0], flags.c}, 9'h002)
    go(LSBA_OP_ROTATE_RIGHT, LSBA_SZ_WORD, 32'hABCD_0003, 0, 1);
    `CHK({res_data, flags.c}, 33'h1_579B_8001)
    go(LSBA_OP_LOGIC_SHIFT_RIGHT, LSBA_SZ_WORD, 32'hFFFF_8001, 0);
    `CHK({res_data, flags.c}, 33'h1_FFFE_8001)
  endtask
  task automatic t_bits();
    go(LSBA_OP_BIT_SET, LSBA_SZ_BYTE, 32'h00, 32'h03, 0, 0, 1);
    `CHK(res_data[7:0], 8'h08)
    go(LSBA_OP_BIT_CLEAR, LSBA_SZ_BYTE, 32'hFF, 32'h38);
    `CHK(res_data[7:0], 8'h7F)
    go(LSBA_OP_BIT_INVERT, LSBA_SZ_BYTE, 32'h5A, 32'h02, 0, 0, 1);
    `CHK(res_data[7:0], 8'h5E)
    go(LSBA_OP_BIT_TEST, LSBA_SZ_BYTE, 32'h20, 32'h28);
    `CHK({flags.z, res_write}, 2'b00)
    go(LSBA_OP_BIT_TEST, LSBA_SZ_BYTE, 32'h20, 32'h28, 0, 0, 1);
    `CHK(flags.z, 1'b1)
  endtask
  task automatic t_carry();
    go(LSBA_OP_LOGIC_SHIFT_LEFT, LSBA_SZ_BYTE, 32'h80, 0);
    `CHK(flags, 3'b011)
    go(LSBA_OP_CARRY_AND_BIT, LSBA_SZ_BYTE, 32'hFE, 32'h08, 0, 0, 1);
    `CHK({flags.c, res_write}, 2'b00)
    go(LSBA_OP_CARRY_OR_BIT, LSBA_SZ_BYTE, 32'h02, 32'h08);
    `CHK(flags.c, 1'b1)
    go(LSBA_OP_CARRY_AND_INVERTED_BIT, LSBA_SZ_BYTE, 32'h04, 32'h17, 0, 0, 1);
    `CHK(flags.c, 1'b0)
    go(LSBA_OP_CARRY_OR_INVERTED_BIT, LSBA_SZ_BYTE, 32'hF7, 32'h1F, 0, 0, 1);
    `CHK(flags.c, 1'b1)
  endtask
  // idle edge drops the strobes; a request under a low enable must not move anything
  task automatic t_enable();
    @(posedge clock) #1;
    `CHK({res_valid, res_write}, 2'b00)
    clk_en = 0;
    req = '{op: LSBA_OP_LOGIC_SHIFT_LEFT, size: LSBA_SZ_LONG, use_imm: 0, two_bits: 0,
            idx_from_reg: 0, idx_imm: 3'h0, dst: 32'h4000_0000, src: 32'h0, imm: 32'h0};
    req_valid = 1;
    repeat (2) @(posedge clock);
    #1;
    `CHK({res_valid, res_data, flags}, {1'b0, 32'h0000_00F7, 3'b011})
    clk_en = 1;
    @(posedge clock) #1;
    req_valid = 0;
    `CHK({res_valid, res_data, flags}, {1'b1, 32'h8000_0000, 3'b100})
  endtask
  initial begin
    reset_n = 0;
    clk_en = 1;
    req_valid = 0;
    req = '0;
    repeat (20) @(posedge clock);
    #1 reset_n = 1;
    `CHK({res_valid, flags}, 4'h0)
    t_logic();
    t_shift();
    t_bits();
    t_carry();
    t_enable();
    wrap_up();
  end
endmodule
